// *** rtl/supervisor_pkg.sv ***
// Behaviour
// - watchdog times 1.6 s without activity, then asserts reset.
// - watchdog activity comes only from the serial data line.
// - a build option removes the watchdog completely.
// - reset outputs are active while the supply is out of tolerance.
// - reset stays asserted 200 ms after the supply recovers.
// - two complementary reset outputs show one internal reset condition.
// - reset pin press is debounced and starts a reset sequence.
// - page writes are buffered in 16-byte units.
// - write-protect input high refuses all memory writes.
// - supply below threshold inhibits memory writes.
// - program cycle starts at stop ending a write, finishes within 10 ms.
// - during program cycle bus is disabled, data line released, address ignored.
// - every data line transition clears the watchdog count.
// - watchdog count held at zero while reset is asserted.
// - watchdog expiry asserts both reset outputs.
// - while reset is active, accesses are ignored and no acknowledge is driven.
package supervisor_pkg;
    localparam int CLK_HZ = 100000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam real WATCHDOG_S = 1.6;
    localparam int WATCHDOG_TICKS = 1600;
    localparam int PURST_MS = 200;
    localparam int PURST_TICKS = PURST_MS / TICK_MS;
    localparam int WRITE_MS = 10;
    localparam int WRITE_TICKS = WRITE_MS / TICK_MS;
    localparam int PAGE_BYTES = 16;
    localparam int PAGE_AW = 4;
    localparam int DATA_W = 8;
    localparam int TICK_W = 17;
    localparam int CNT_W = 11;
    localparam logic [7:0] PAGE_RESET_BYTE = 8'hFF;
    typedef enum logic [1:0] {RS_RUN, RS_HOLD, RS_TIMEOUT} reset_state_t;
endpackage

// *** rtl/page_buf_if.sv ***
`timescale 1ns/1ns
interface page_buf_if;
    import supervisor_pkg::*;
    logic wr_en;
    logic [PAGE_AW-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [PAGE_AW-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// *** rtl/page_buffer.sv ***
`timescale 1ns/1ns
module page_buffer
    import supervisor_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    page_buf_if.mem buf_port
);
    logic [DATA_W-1:0] mem_reg [PAGE_BYTES];
    logic [DATA_W-1:0] rd_reg;

    assign buf_port.rd_data = rd_reg;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_reg <= PAGE_RESET_BYTE;
        end else begin
            rd_reg <= mem_reg[buf_port.rd_addr];
        end
    end

    // one page of 16 bytes holds a write sequence before programming
    always_ff @(posedge clk_in) begin
        if (buf_port.wr_en) begin
            mem_reg[buf_port.wr_addr] <= buf_port.wr_data;
        end
    end
endmodule // page_buffer

// *** rtl/supervisor_watchdog_write_lock.sv ***
`timescale 1ns/1ns
module supervisor_watchdog_write_lock
    import supervisor_pkg::*;
#(
    parameter bit WATCHDOG_EN = 1'b1,
    parameter int TICK_DIV = TICK_CYCLES,
    parameter int WDOG_TICKS = WATCHDOG_TICKS,
    parameter int TIMEOUT_TICKS = PURST_TICKS,
    parameter int PROG_TICKS = WRITE_TICKS
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic supply_ok_in,
    input wire logic wp_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic rst_hi_pin_in,
    input wire logic rst_lo_n_pin_in,
    input wire logic ack_drive_in,
    input wire logic write_seq_in,
    input wire logic page_wr_in,
    input wire logic [PAGE_AW-1:0] page_wr_addr_in,
    input wire logic [DATA_W-1:0] page_wr_data_in,
    input wire logic [PAGE_AW-1:0] page_rd_addr_in,
    output logic [DATA_W-1:0] page_rd_data_out,
    output logic rst_hi_out,
    output logic rst_hi_oe_out,
    output logic rst_lo_n_out,
    output logic rst_lo_n_oe_out,
    output logic sda_out,
    output logic sda_oe_out,
    output logic bus_enable_out,
    output logic prog_active_out
);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);
    localparam logic [CNT_W-1:0] WDOG_LAST = CNT_W'(WDOG_TICKS - 1);
    localparam logic [CNT_W-1:0] TIMEOUT_LAST = CNT_W'(TIMEOUT_TICKS - 1);
    localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_TICKS - 1);

    // two-stage synchronisers for every pin
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic sda_prev_reg;
    logic scl_prev_reg;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            // pins start at their idle levels so no false edge follows reset
            sync1_reg <= 6'h38;
            sync2_reg <= 6'h38;
            sda_prev_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
        end else begin
            sync1_reg <= {sda_in, scl_in, rst_lo_n_pin_in, rst_hi_pin_in, wp_in, supply_ok_in};
            sync2_reg <= sync1_reg;
            sda_prev_reg <= sync2_reg[5];
            scl_prev_reg <= sync2_reg[4];
        end
    end
    wire supply_ok = sync2_reg[0];
    wire wp_s = sync2_reg[1];
    wire hi_pin_s = sync2_reg[2];
    wire lo_n_pin_s = sync2_reg[3];
    wire scl_s = sync2_reg[4];
    wire sda_s = sync2_reg[5];
    wire sda_edge = sda_s ^ sda_prev_reg;
    wire stop_seen = scl_s && scl_prev_reg && sda_s && !sda_prev_reg;

    // reference tick shared by all intervals
    logic [TICK_W-1:0] tick_cnt_reg;
    wire tick = (tick_cnt_reg == TICK_LAST);
    always_ff @(posedge clk_in) begin
        if (rst_in || tick) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
        end
    end

    // manual reset: pins sampled each tick, a press counts when seen at one tick after an idle sample
    logic hi_smp_reg;
    logic lo_n_smp_reg;
    reset_state_t state_reg;
    wire reset_active = (state_reg != RS_RUN);
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hi_smp_reg <= 1'b0;
            lo_n_smp_reg <= 1'b1;
        end else if (tick) begin
            hi_smp_reg <= hi_pin_s;
            lo_n_smp_reg <= lo_n_pin_s;
        end
    end
    wire hi_rise = tick && !hi_smp_reg && hi_pin_s;
    wire lo_fall = tick && lo_n_smp_reg && !lo_n_pin_s;
    wire manual_press = !reset_active && (hi_rise || lo_fall);

    // watchdog on the data line only
    logic [CNT_W-1:0] wdog_cnt_reg;
    logic [CNT_W-1:0] wdog_cnt_next;
    wire wdog_expire = WATCHDOG_EN && tick && (wdog_cnt_reg == WDOG_LAST);
    always_comb begin
        wdog_cnt_next = wdog_cnt_reg;
        if (!WATCHDOG_EN || reset_active) begin
            wdog_cnt_next = '0;
        end else if (sda_edge) begin
            wdog_cnt_next = '0;
        end else if (tick) begin
            wdog_cnt_next = wdog_cnt_reg + 1'b1;
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wdog_cnt_reg <= '0;
        end else begin
            wdog_cnt_reg <= wdog_cnt_next;
        end
    end

    // reset sequencer
    logic [CNT_W-1:0] to_cnt_reg;
    reset_state_t state_next;
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            RS_RUN: begin
                if (!supply_ok) begin
                    state_next = RS_HOLD;
                end else if (wdog_expire || manual_press) begin
                    state_next = RS_TIMEOUT;
                end
            end
            RS_HOLD: begin
                if (supply_ok) begin
                    state_next = RS_TIMEOUT;
                end
            end
            RS_TIMEOUT: begin
                if (!supply_ok) begin
                    state_next = RS_HOLD;
                end else if (tick && to_cnt_reg == TIMEOUT_LAST) begin
                    state_next = RS_RUN;
                end
            end
            default: begin
                state_next = RS_HOLD;
            end
        endcase
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg <= RS_HOLD;
            to_cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            if (state_next != RS_TIMEOUT || state_reg != RS_TIMEOUT) begin
                to_cnt_reg <= '0;
            end else if (tick) begin
                to_cnt_reg <= to_cnt_reg + 1'b1;
            end
        end
    end

    // write lock and program cycle
    logic busy_reg;
    logic [CNT_W-1:0] prog_cnt_reg;
    wire write_allowed = !wp_s && supply_ok && !reset_active;
    wire prog_start = !busy_reg && stop_seen && write_seq_in && write_allowed;
    wire prog_done = busy_reg && tick && (prog_cnt_reg == PROG_LAST);
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            busy_reg <= 1'b0;
            prog_cnt_reg <= '0;
        end else begin
            if (prog_start) begin
                busy_reg <= 1'b1;
                prog_cnt_reg <= '0;
            end else if (prog_done) begin
                busy_reg <= 1'b0;
            end else if (busy_reg && tick) begin
                prog_cnt_reg <= prog_cnt_reg + 1'b1;
            end
        end
    end

    wire bus_en = !busy_reg && !reset_active;
    wire buf_wr = page_wr_in && bus_en && write_allowed;

    page_buf_if pbuf ();
    assign pbuf.wr_en = buf_wr;
    assign pbuf.wr_addr = page_wr_addr_in;
    assign pbuf.wr_data = page_wr_data_in;
    assign pbuf.rd_addr = page_rd_addr_in;

    page_buffer u_page_buffer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .buf_port(pbuf)
    );

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rst_hi_out <= 1'b1;
            rst_hi_oe_out <= 1'b1;
            rst_lo_n_out <= 1'b0;
            rst_lo_n_oe_out <= 1'b1;
            sda_out <= 1'b0;
            sda_oe_out <= 1'b0;
            bus_enable_out <= 1'b0;
            prog_active_out <= 1'b0;
            page_rd_data_out <= PAGE_RESET_BYTE;
        end else begin
            rst_hi_out <= reset_active;
            rst_hi_oe_out <= reset_active;
            rst_lo_n_out <= !reset_active;
            rst_lo_n_oe_out <= reset_active;
            sda_out <= 1'b0;
            // the bus drops in the same cycle as the program cycle starts
            sda_oe_out <= ack_drive_in && bus_en && !prog_start;
            bus_enable_out <= bus_en && !prog_start;
            prog_active_out <= busy_reg || prog_start;
            page_rd_data_out <= pbuf.rd_data;
        end
    end
endmodule // supervisor_watchdog_write_lock

// *** verif/supervisor_asserts.sv ***
`timescale 1ns/1ns
module sup_asserts(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic supply_ok_in,
    input wire logic wp_in,
    input wire logic rst_hi_out,
    input wire logic rst_hi_oe_out,
    input wire logic rst_lo_n_out,
    input wire logic rst_lo_n_oe_out,
    input wire logic sda_oe_out,
    input wire logic bus_enable_out,
    input wire logic prog_active_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    chk_rst_pair: assert property (rst_lo_n_out == !rst_hi_out) else $error("reset pair differs");
    chk_rst_drive: assert property (rst_hi_oe_out == rst_hi_out && rst_lo_n_oe_out == rst_hi_out) else $error("oe");
    chk_supply_low: assert property (!supply_ok_in |-> ##[1:5] rst_hi_out) else $error("no reset");
    chk_timeout_hold: assert property ($rose(supply_ok_in) |-> ##3 rst_hi_out[*8]) else $error("early");
    chk_rst_quiet: assert property (rst_hi_out |-> !sda_oe_out && !bus_enable_out)
        else $error("bus active in reset");
    chk_prog_quiet: assert property (prog_active_out |-> !sda_oe_out && !bus_enable_out)
        else $error("bus active in program");
    chk_prog_len: assert property ($rose(prog_active_out) |-> prog_active_out[*8] ##[10:25] !prog_active_out)
        else $error("program length");
    chk_prog_gate: assert property ($rose(prog_active_out) |-> !$past(wp_in, 3) && $past(supply_ok_in, 3))
        else $error("program not allowed");
    cover property ($rose(prog_active_out));
    cover property ($rose(rst_hi_out) && supply_ok_in);
    cover property (sda_oe_out);
endmodule // sup_asserts
bind supervisor_watchdog_write_lock sup_asserts chk (.*);

// *** verif/host_model.sv ***
`timescale 1ns/1ns
module host_model(
    input wire logic clk_in,
    input wire logic alive_in,
    output logic scl_out,
    output logic sda_low_out
);
    int cnt = 0;
    initial begin
        scl_out = 1'b0;
        sda_low_out = 1'b0;
    end
    always @(posedge clk_in) begin
        cnt <= cnt + 1;
        if (alive_in && cnt % 40 == 0) begin
            sda_low_out <= !sda_low_out;
        end
    end
    // stop: data released while the clock is high
    task automatic stop_cond();
        sda_low_out <= 1'b1;
        repeat (8) @(posedge clk_in);
        scl_out <= 1'b1;
        repeat (8) @(posedge clk_in);
        sda_low_out <= 1'b0;
        repeat (8) @(posedge clk_in);
        scl_out <= 1'b0;
    endtask
endmodule // host_model

// *** verif/test_supervisor_watchdog_write_lock.sv ***
`timescale 1ns/1ns
module test_supervisor_watchdog_write_lock;
    import supervisor_pkg::*;
    logic clk_in = 0, rst_in = 1, supply_ok_in = 1, wp_in = 0, ack_drive_in = 0, write_seq_in = 0, page_wr_in = 0;
    logic [PAGE_AW-1:0] page_wr_addr_in = '0, page_rd_addr_in = '0;
    logic [DATA_W-1:0] page_wr_data_in = '0, page_rd_data_out;
    logic rst_hi_out, rst_hi_oe_out, rst_lo_n_out, rst_lo_n_oe_out, sda_out, sda_oe_out, bus_enable_out;
    logic prog_active_out, btn_lo = 0, alive = 0, scl_in, sda_low, nowd_rst_hi;
    logic [15:0] rnd = 16'h0553;
    logic [7:0] exp_mem [PAGE_BYTES];
    int fail_count = 0, checks_done = 0, n;
    wire sda_in = !(sda_low | sda_oe_out);
    wire rst_hi_pin_in = rst_hi_oe_out & rst_hi_out;
    wire rst_lo_n_pin_in = !(btn_lo | (rst_lo_n_oe_out & !rst_lo_n_out));
    supervisor_watchdog_write_lock #(.TICK_DIV(10), .WDOG_TICKS(20), .TIMEOUT_TICKS(5), .PROG_TICKS(3)) uut (.*);
    host_model host (.clk_in(clk_in), .alive_in(alive), .scl_out(scl_in), .sda_low_out(sda_low));
    // second build without the watchdog, its reset pins held at their idle levels
    supervisor_watchdog_write_lock #(.WATCHDOG_EN(1'b0), .TICK_DIV(10), .WDOG_TICKS(20), .TIMEOUT_TICKS(5),
        .PROG_TICKS(3)) uut_nowd (
        .clk_in(clk_in), .rst_in(rst_in), .supply_ok_in(supply_ok_in), .wp_in(wp_in), .scl_in(scl_in),
        .sda_in(sda_in), .rst_hi_pin_in(1'b0), .rst_lo_n_pin_in(1'b1), .ack_drive_in(1'b0), .write_seq_in(1'b0),
        .page_wr_in(1'b0), .page_wr_addr_in(page_wr_addr_in), .page_wr_data_in(page_wr_data_in),
        .page_rd_addr_in(page_rd_addr_in), .page_rd_data_out(), .rst_hi_out(nowd_rst_hi), .rst_hi_oe_out(),
        .rst_lo_n_out(), .rst_lo_n_oe_out(), .sda_out(), .sda_oe_out(), .bus_enable_out(), .prog_active_out()
    );
    initial forever #5 clk_in = ~clk_in;
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_hi(input logic v, input int lim, output int cyc);
        cyc = 0;
        while (rst_hi_out !== v && cyc < lim) begin
            @(posedge clk_in);
            cyc++;
        end
        check(rst_hi_out, v);
        check(rst_lo_n_out, !v);
        if (rst_hi_out !== v) test_done();
    endtask
    // writes a random page, then reads every byte back against the model
    task automatic page_pass(input bit ok);
        logic [7:0] d;
        for (int a = 0; a < PAGE_BYTES; a++) begin
            rnd = lfsr(rnd);
            @(posedge clk_in);
            page_wr_in <= 1;
            page_wr_addr_in <= a[3:0];
            page_wr_data_in <= rnd[7:0];
            @(posedge clk_in);
            page_wr_in <= 0;
            if (ok) exp_mem[a] = rnd[7:0];
        end
        for (int a = 0; a < PAGE_BYTES; a++) begin
            @(posedge clk_in);
            page_rd_addr_in <= a[3:0];
            repeat (4) @(posedge clk_in);
            d = page_rd_data_out;
            check(d, exp_mem[a]);
        end
    endtask
    task automatic stop_try(input bit exp);
        alive <= 0;
        write_seq_in <= 1;
        @(posedge clk_in);
        host.stop_cond();
        write_seq_in <= 0;
        ack_drive_in <= 1;
        repeat (4) @(posedge clk_in);
        check(prog_active_out, exp);
        check(sda_oe_out, !exp);
        check(bus_enable_out, !exp);
        check(sda_out, 0);
        n = 0;
        while (prog_active_out === 1'b1 && n < 60) begin
            @(posedge clk_in);
            n++;
        end
        check(n >= 14 && n <= 30, exp);
        ack_drive_in <= 0;
        alive <= 1;
    endtask
    initial begin
        foreach (exp_mem[i]) exp_mem[i] = PAGE_RESET_BYTE;
        repeat (12) @(posedge clk_in);
        rst_in <= 0;
        wait_hi(0, 200, n);
        check(n >= 40 && n <= 70, 1);
        alive <= 1;
        page_pass(1);
        @(posedge clk_in);
        wp_in <= 1;
        repeat (3) @(posedge clk_in);
        page_pass(0);
        stop_try(0);
        wp_in <= 0;
        stop_try(1);
        repeat (300) @(posedge clk_in);
        check(rst_hi_out, 0);
        alive <= 0;
        wait_hi(1, 260, n);
        check(n >= 150, 1);
        check(nowd_rst_hi, 0);
        wait_hi(0, 120, n);
        wait_hi(1, 260, n);
        check(n >= 190, 1);
        wait_hi(0, 120, n);
        alive <= 1;
        // the released pin must be seen idle at a tick before a press counts
        repeat (25) @(posedge clk_in);
        btn_lo <= 1;
        wait_hi(1, 40, n);
        btn_lo <= 0;
        wait_hi(0, 120, n);
        supply_ok_in <= 0;
        repeat (5) @(posedge clk_in);
        check(rst_hi_out, 1);
        page_pass(0);
        supply_ok_in <= 1;
        wait_hi(0, 120, n);
        check(n >= 40, 1);
        test_done();
    end
endmodule // test_supervisor_watchdog_write_lock
